// File: inc/irl_pkg.sv
// Constants for the interrupt request logic and its APB register map
package irl_pkg;
  localparam int unsigned ADDR_W = 12;
  // Register byte addresses
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_PFLAG1 = 12'h004;
  localparam logic [11:0] OFF_PFLAG2 = 12'h008;
  localparam logic [11:0] OFF_PMASK1 = 12'h00C;
  localparam logic [11:0] OFF_PMASK2 = 12'h010;
  localparam logic [11:0] OFF_OPTION = 12'h014;
  localparam logic [11:0] OFF_PCSEL = 12'h018;
  localparam logic [11:0] OFF_ANSEL = 12'h01C;
  localparam logic [11:0] OFF_TICK = 12'h020;
  localparam logic [11:0] OFF_CORE = 12'h024;
  localparam logic [11:0] OFF_PORT = 12'h028;
  // irq_control_reg bit positions
  localparam int unsigned B_GIE = 7;
  localparam int unsigned B_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int unsigned B_TOIE = 5;
  localparam int unsigned B_EIE = 4;
  localparam int unsigned B_PCIE = 3;
  localparam int unsigned B_TOIF = 2;
  localparam int unsigned B_EIF = 1;
  localparam int unsigned B_PCIF = 0;
  // Option register bit, core status register bits
  localparam int unsigned B_EDGE = 0;
  localparam int unsigned B_SLEEP = 0;
  localparam int unsigned B_SERVICE = 1;
  // Reset values and masks
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'h01;
  localparam logic [7:0] ANSEL_RST = 8'hFF;
  localparam logic [7:0] PFLAG2_MASK = 8'hF3;
  // Vector address and tick counter top value (rollover from this to zero)
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [7:0] TICK_TOP = 8'hFF;
  // Core sequencer states
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKE = 3'b100
  } irl_state_t;
endpackage

// File: hw/irl_top.sv
// Interrupt request logic with APB register file and core control handshake
// What this block does
// - Each source sets its flag regardless of any enable bit.
// - Global enable set allows unmasked interrupts; cleared blocks all.
// - A cleared individual enable blocks its source.
// - Global enable is zero after every reset.
// - Servicing clears global enable, pushes return address, jumps to 0004h.
// - Return from interrupt sets global enable again.
// - Pin, change, tick bits in control reg; peripheral flags and masks apart.
// - External events are serviced three or four instruction cycles later.
// - Latency does not depend on one- or two-cycle instructions.
// - Clearing global enable cancels the next-cycle interrupt; it stays pending.
// - External pin edge: rising when edge select is one, else falling.
// - Valid pin edge sets its flag; its enable gates the interrupt.
// - Pin edge wakes from sleep if its enable was set before sleep.
// - Analog pins read zero and raise no edge or change interrupt.
// - Tick counter rollover FFh to 00h sets its flag, gated by its enable.
// - A change on a selected port pin sets the change flag.
// - A change coinciding with a port instruction may be missed.
// - Wake with global enable set runs PC+1, then vectors to 0004h.
// - The external flag may be set anywhere in the Q4-Q1 window.
// - Peripheral interrupts need the peripheral enable.
module irl_top
  import irl_pkg::*;
#(
  parameter int unsigned PORT_W = 8
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [irl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and peripheral events
  input wire logic [PORT_W-1:0] port_pins,
  input wire logic ext_irq_pin,
  input wire logic tick_inc,
  input wire logic [7:0] periph_evt_1,
  input wire logic [7:0] periph_evt_2,
  // Core sequencer side
  input wire logic instr_done,
  input wire logic sleep_req,
  input wire logic return_from_irq,
  input wire logic port_op,
  input wire logic [12:0] pc_next,
  output logic vector_take,
  output logic [12:0] vector_pc,
  output logic push_stack,
  output logic [12:0] push_addr,
  output logic core_asleep,
  output logic irq_pending
);
  import irl_pkg::*;

  // Register map, one 8-bit register per 32-bit word, upper bits read zero:
  //   000 control: global, peripheral and source enables plus three flags
  //   004 peripheral flags 1, set by event lines, cleared by software
  //   008 peripheral flags 2, bits 3:2 unused and read zero
  //   00C peripheral mask 1
  //   010 peripheral mask 2, same unused bits as flags 2
  //   014 option: bit 0 picks the external edge, one for rising
  //   018 pin-change select, one bit per port pin
  //   01C analog select, one bit per port pin, all analog after reset
  //   020 tick counter, writable so software can preload it
  //   024 core status: bit 0 asleep, bit 1 take this cycle
  //   028 port read, analog pins forced to zero
  // Unmapped offsets answer with an error and ignore writes.
  // Every register answers with no wait state.
  // Flags are set by hardware and cleared only by software writes.

  logic [7:0] irq_control_reg;
  logic [7:0] periph_flag_reg_1;
  logic [7:0] periph_flag_reg_2;
  logic [7:0] periph_mask_reg_1;
  logic [7:0] periph_mask_reg_2;
  logic [7:0] option_reg;
  logic [PORT_W-1:0] pin_change_select_reg;
  logic [PORT_W-1:0] analog_select_reg;
  logic [7:0] tick_counter;
  logic [PORT_W-1:0] port_meta, port_sync, port_last;
  logic ext_meta, ext_sync, ext_last;
  logic [1:0] lat_pipe;
  logic ext_en_at_sleep;
  irl_state_t state;

  // Writes act in the access cycle; reads were captured one cycle earlier,
  // so read data is ready in the same cycle as pready.
  // Back-to-back transfers need no idle cycle in between.
  // Bus decode
  logic wr_en, rd_en;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  // Address match, shared by every register write decode
  // Full compare, so aliases of a register answer as unmapped
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // Edge of the chosen polarity between two successive samples
  // Used for the external pin; the port uses a plain change compare
  function automatic logic edge_seen(input logic now, input logic was, input logic rise);
    return rise ? (now & ~was) : (~now & was);
  endfunction

  // Two flops on every pin before any logic reads it; the first flop
  // may go metastable and is read by nothing but the second.
  // Pins pass two flops; analog pins read zero
  logic [PORT_W-1:0] port_dig;
  logic ext_dig;
  assign port_dig = port_sync & ~analog_select_reg;
  assign ext_dig = ext_sync & ~analog_select_reg[2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_meta <= '0;
      port_sync <= '0;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end else begin
      port_meta <= port_pins;
      port_sync <= port_meta;
      ext_meta <= ext_irq_pin;
      ext_sync <= ext_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Reset matches the all-analog view, so no false edge after reset
      port_last <= '0;
      ext_last <= 1'b0;
    end else begin
      port_last <= port_dig;
      ext_last <= ext_dig;
    end
  end

  // Edge history follows the digital view of each pin, so turning a pin
  // from analog to digital can itself look like an edge or a change.
  // Software should clear the flags after changing analog select.
  // Source events
  logic ext_evt, pc_evt, tick_wr, tick_evt;
  assign ext_evt = edge_seen(ext_dig, ext_last, option_reg[B_EDGE]);
  // Change during a port instruction is dropped, as on the original part
  assign pc_evt = |((port_dig ^ port_last) & pin_change_select_reg) & ~port_op;
  assign tick_wr = wr_en & hit(paddr, OFF_TICK);
  assign tick_evt = tick_inc & ~tick_wr & (tick_counter == TICK_TOP);

  // A software load wins over an increment in the same cycle, and a load
  // of a full counter does not count as a rollover.
  // The counter keeps running whatever the flag or enable state.
  // Tick counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_counter <= 8'h00;
    end else if (tick_wr) begin
      tick_counter <= pwdata[7:0];
    end else if (tick_inc) begin
      tick_counter <= tick_counter + 8'h01;
    end
  end

  // Each flag is gated by its own enable; peripheral terms also need the
  // peripheral enable. The pending view leaves out the global enable so
  // that sleep wake-up still sees a request with interrupts off.
  // Request combine
  logic periph_req, unmasked, req;
  assign periph_req = |(periph_flag_reg_1 & periph_mask_reg_1) | |(periph_flag_reg_2 & periph_mask_reg_2);
  assign unmasked = (irq_control_reg[B_TOIF] & irq_control_reg[B_TOIE])
                  | (irq_control_reg[B_EIF] & irq_control_reg[B_EIE])
                  | (irq_control_reg[B_PCIF] & irq_control_reg[B_PCIE])
                  | (periph_req & irq_control_reg[B_PERIPHERAL_IRQ_ENABLE]);
  assign req = unmasked & irq_control_reg[B_GIE];

  // Software write that clears the global enable cancels any take this cycle
  logic gie_clr_wr, take, wake;
  assign gie_clr_wr = wr_en & hit(paddr, OFF_CTRL) & ~pwdata[B_GIE];
  // Latency pipe counts instruction boundaries, not clocks, so 2-cycle ops match
  assign take = lat_pipe[1] & req & ~gie_clr_wr & instr_done & (state == ST_RUN);
  assign wake = (state == ST_SLEEP) & ((irq_control_reg[B_EIF] & ext_en_at_sleep) | (unmasked & ~irq_control_reg[B_EIF]));

  // Latency pipe: two instruction boundaries must pass with the request held
  // before the take, which lands three or four cycles after the event
  // depending on where in the instruction it arrived.
  // Any drop of the request, by a cleared flag, enable or global enable,
  // restarts the count, so a stale half-count never shortens a later take.
  // Counting boundaries instead of clocks keeps two-cycle instructions level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_pipe <= 2'b00;
    end else if (!req) begin
      lat_pipe <= 2'b00;
    end else if (instr_done) begin
      lat_pipe <= {lat_pipe[0], 1'b1};
    end
  end

  // Order inside this process matters: the software write lands first,
  // the hardware change of the global enable next, and the flag sets last,
  // so an event in the same cycle as a software clear is kept.
  // A take has priority over a return so the enable never reopens early.
  // Control register: hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_control_reg <= CTRL_RST;
    end else begin
      if (wr_en && hit(paddr, OFF_CTRL)) begin
        irq_control_reg <= pwdata[7:0];
      end
      if (take) begin
        irq_control_reg[B_GIE] <= 1'b0;
      end else if (return_from_irq) begin
        irq_control_reg[B_GIE] <= 1'b1;
      end
      if (ext_evt) begin
        irq_control_reg[B_EIF] <= 1'b1;
      end
      if (pc_evt) begin
        irq_control_reg[B_PCIF] <= 1'b1;
      end
      if (tick_evt) begin
        irq_control_reg[B_TOIF] <= 1'b1;
      end
    end
  end

  // Event lines are ORed in every cycle, the write cycle included, so a
  // flag that fires while software clears it is never lost.
  // Unused bits of the second flag register are masked on both paths.
  // Peripheral flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_flag_reg_1 <= 8'h00;
      periph_flag_reg_2 <= 8'h00;
    end else begin
      if (wr_en && hit(paddr, OFF_PFLAG1)) begin
        periph_flag_reg_1 <= pwdata[7:0] | periph_evt_1;
      end else begin
        periph_flag_reg_1 <= periph_flag_reg_1 | periph_evt_1;
      end
      if (wr_en && hit(paddr, OFF_PFLAG2)) begin
        periph_flag_reg_2 <= (pwdata[7:0] | periph_evt_2) & PFLAG2_MASK;
      end else begin
        periph_flag_reg_2 <= (periph_flag_reg_2 | periph_evt_2) & PFLAG2_MASK;
      end
    end
  end

  // No hardware path touches these; they hold what software wrote, except mask 2 bits 3:2, which stay zero.
  // Analog select resets to all ones so floating pins cannot raise edges
  // or changes until software configures them.
  // Plain configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_mask_reg_1 <= 8'h00;
      periph_mask_reg_2 <= 8'h00;
      option_reg <= OPTION_RST;
      pin_change_select_reg <= '0;
      analog_select_reg <= PORT_W'(ANSEL_RST);
    end else if (wr_en) begin
      if (hit(paddr, OFF_PMASK1)) periph_mask_reg_1 <= pwdata[7:0];
      if (hit(paddr, OFF_PMASK2)) periph_mask_reg_2 <= pwdata[7:0] & PFLAG2_MASK;
      if (hit(paddr, OFF_OPTION)) option_reg <= pwdata[7:0];
      if (hit(paddr, OFF_PCSEL)) pin_change_select_reg <= pwdata[PORT_W-1:0];
      if (hit(paddr, OFF_ANSEL)) analog_select_reg <= pwdata[PORT_W-1:0];
    end
  end

  // The external enable is sampled on entry to sleep, since only an enable
  // that was already set may let a pin edge wake the core.
  // Other sources wake on any unmasked flag while the external flag is clear, whatever the global enable.
  // The wake state holds until one instruction boundary has passed, which
  // lets the instruction after the sleep run before a take can fire.
  // Sleep sequencer: wake runs PC+1 first, then vectors if global enable set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_RUN;
      ext_en_at_sleep <= 1'b0;
    end else begin
      unique case (state)
        ST_RUN: begin
          if (sleep_req) begin
            state <= ST_SLEEP;
            ext_en_at_sleep <= irq_control_reg[B_EIE];
          end
        end
        ST_SLEEP: begin
          if (wake) state <= ST_WAKE;
        end
        ST_WAKE: begin
          if (instr_done) state <= ST_RUN;
        end
      endcase
    end
  end

  // All core-side outputs come from flops, so the core sees them one cycle
  // after the take decision. The vector is constant but still registered
  // to keep every output of the block on a flop.
  // The pushed address is held between takes for the core to read.
  // Core control outputs, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_take <= 1'b0;
      push_stack <= 1'b0;
      push_addr <= 13'h0000;
      vector_pc <= IRQ_VECTOR;
      core_asleep <= 1'b0;
      irq_pending <= 1'b0;
    end else begin
      vector_take <= take;
      push_stack <= take;
      if (take) push_addr <= pc_next;
      vector_pc <= IRQ_VECTOR;
      core_asleep <= (state == ST_SLEEP) & ~wake;
      irq_pending <= unmasked;
    end
  end

  // Read data is captured in the setup cycle and shown in the access cycle
  // together with pready. Between transfers read data returns to zero so
  // stale register contents never sit on the bus.
  // APB read data and answer
  logic [7:0] core_status;
  assign core_status = {6'h00, take, state == ST_SLEEP};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        unique case (paddr)
          OFF_CTRL: prdata <= {24'h000000, irq_control_reg};
          OFF_PFLAG1: prdata <= {24'h000000, periph_flag_reg_1};
          OFF_PFLAG2: prdata <= {24'h000000, periph_flag_reg_2};
          OFF_PMASK1: prdata <= {24'h000000, periph_mask_reg_1};
          OFF_PMASK2: prdata <= {24'h000000, periph_mask_reg_2};
          OFF_OPTION: prdata <= {24'h000000, option_reg};
          OFF_PCSEL: prdata <= 32'(pin_change_select_reg);
          OFF_ANSEL: prdata <= 32'(analog_select_reg);
          OFF_TICK: prdata <= {24'h000000, tick_counter};
          OFF_CORE: prdata <= {24'h000000, core_status};
          OFF_PORT: prdata <= 32'(port_dig);
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Reads have no side effect here; the strobe is kept for a later
  // read-to-clear register and is otherwise unused.
  logic unused_rd;
  assign unused_rd = rd_en;
endmodule

// File: sim/irl_top_monitor.sv
// Port checker for the interrupt request logic
module irl_top_monitor
  import irl_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Core side
  input wire logic [12:0] pc_next,
  input wire logic vector_take,
  input wire logic [12:0] vector_pc,
  input wire logic push_stack,
  input wire logic [12:0] push_addr,
  input wire logic core_asleep,
  input wire logic irq_pending
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Vectoring: fixed target, paired push, one shot
  vec_addr_a: assert property (vector_take |-> vector_pc == IRQ_VECTOR) else $error("bad vector");
  take_push_a: assert property (vector_take == push_stack) else $error("push unpaired");
  push_addr_a: assert property (vector_take |-> push_addr == $past(pc_next)) else $error("bad return");
  take_once_a: assert property (vector_take |=> !vector_take [*2]) else $error("take repeated");
  take_cause_a: assert property (vector_take |-> $past(irq_pending)) else $error("take uncaused");
  rst_quiet_a: assert property ($rose(presetn) |-> !vector_take [*3]) else $error("take after reset");
  sleep_take_a: assert property (core_asleep |-> !vector_take) else $error("take asleep");
  // Zero-wait bus answer, one cycle wide
  bus_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
  ready_one_a: assert property (pready |=> !pready) else $error("ready stuck");
  err_ready_a: assert property (pslverr |-> pready) else $error("lone error");
endmodule

bind irl_top irl_top_monitor mon (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .pc_next,
  .vector_take, .vector_pc, .push_stack, .push_addr, .core_asleep, .irq_pending);

// File: sim/irl_core_model.sv
// Behavioural core sequencer: instruction boundaries and program counter
module irl_core_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Cycles per instruction less one
  input wire logic [1:0] gap,
  // Vector request
  input wire logic vector_take,
  input wire logic [12:0] vector_pc,
  // Sequencer outputs
  output logic instr_done,
  output logic [12:0] pc_next
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;
  // Boundary every gap+1 cycles, so slow multi-cycle instructions show up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 2'h0;
      instr_done <= 1'b0;
    end else begin
      instr_done <= (cnt == gap);
      cnt <= (cnt == gap) ? 2'h0 : cnt + 2'h1;
    end
  end
  // Counter steps at boundaries; a take jumps to the vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_next <= 13'h0000;
    end else if (vector_take) begin
      pc_next <= vector_pc + 13'h0001;
    end else if (instr_done) begin
      pc_next <= pc_next + 13'h0001;
    end
  end
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the interrupt request logic
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import irl_pkg::*;
  // Stimulus, all defined at time zero
  logic pclk, pready, pslverr, last_err, instr_done, vector_take, push_stack, core_asleep, irq_pending;
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [7:0] port_pins = 8'h00, periph_evt_1 = 8'h00, periph_evt_2 = 8'h00, m;
  logic ext_irq_pin = 1'b0, tick_inc = 1'b0, sleep_req = 1'b0, return_from_irq = 1'b0, port_op = 1'b0;
  logic [12:0] pc_next, vector_pc, push_addr;
  logic [1:0] gap = 2'h0;
  logic [31:0] lfsr = 32'h63AD;
  int num_errors = 0;
  int cmp_count = 0;

  irl_top #(.PORT_W(8)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .port_pins, .ext_irq_pin, .tick_inc, .periph_evt_1, .periph_evt_2, .instr_done, .sleep_req,
    .return_from_irq, .port_op, .pc_next, .vector_take, .vector_pc, .push_stack, .push_addr, .core_asleep,
    .irq_pending);
  irl_core_model core (.pclk, .presetn, .gap, .vector_take, .vector_pc, .instr_done, .pc_next);

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One bus transfer; request held until ready is sampled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) begin
      num_errors++;
      give_verdict();
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask

  // Bounded watch for a vector take
  task automatic wait_take(input logic exp);
    int n;
    n = 0;
    while (vector_take !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk("take", {31'h0, exp}, {31'h0, n < 40});
    idle(1);
  endtask

  task automatic give_verdict();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("ctrl", OFF_CTRL, 32'h00);
    rd_chk("option", OFF_OPTION, 32'h01);
    rd_chk("analog", OFF_ANSEL, 32'hFF);
    apb(1'b0, 12'h100, 32'h0);
    chk("slverr", 32'h1, {31'h0, last_err});
    // Analog pins read zero, digital ones follow
    m = lfsr[7:0];
    port_pins <= m;
    idle(3);
    rd_chk("port analog", OFF_PORT, 32'h00);
    apb(1'b1, OFF_ANSEL, 32'h00);
    rd_chk("port digital", OFF_PORT, {24'h0, m});
    // Each edge select: wrong edge ignored, valid edge flags
    for (int e = 0; e < 2; e++) begin
      // Park the pin at the valid level first so the next step is a wrong edge
      ext_irq_pin <= e[0];
      idle(4);
      apb(1'b1, OFF_OPTION, 32'(e));
      apb(1'b1, OFF_CTRL, 32'h00);
      ext_irq_pin <= !e[0];
      idle(4);
      rd_chk("wrong edge", OFF_CTRL, 32'h00);
      ext_irq_pin <= e[0];
      idle(4);
      rd_chk("valid edge", OFF_CTRL, 32'h02);
    end
    // Analog pin raises nothing
    apb(1'b1, OFF_ANSEL, 32'h04);
    apb(1'b1, OFF_CTRL, 32'h00);
    ext_irq_pin <= 1'b0;
    idle(4);
    ext_irq_pin <= 1'b1;
    idle(4);
    rd_chk("analog edge", OFF_CTRL, 32'h00);
    apb(1'b1, OFF_ANSEL, 32'h00);
    // Pin change on random selection
    lfsr = next_rand(lfsr);
    m = lfsr[7:0] | 8'h01;
    apb(1'b1, OFF_PCSEL, {24'h0, m});
    apb(1'b1, OFF_CTRL, 32'h00);
    port_pins <= port_pins ^ ~m;
    idle(4);
    rd_chk("unselected change", OFF_CTRL, 32'h00);
    port_pins <= port_pins ^ 8'h01;
    idle(4);
    rd_chk("selected change", OFF_CTRL, 32'h01);
    // Change during a port instruction is dropped by this design
    apb(1'b1, OFF_CTRL, 32'h00);
    port_op <= 1'b1;
    port_pins <= port_pins ^ 8'h01;
    idle(4);
    port_op <= 1'b0;
    rd_chk("change in port op", OFF_CTRL, 32'h00);
    // Tick rollover FE, FF, 00
    apb(1'b1, OFF_CTRL, 32'h00);
    apb(1'b1, OFF_TICK, 32'hFE);
    for (int i = 0; i < 2; i++) begin
      tick_inc <= 1'b1;
      idle(1);
      tick_inc <= 1'b0;
      idle(2);
      rd_chk("tick flag", OFF_CTRL, (i == 1) ? 32'h04 : 32'h00);
    end
    // Peripheral flag through mask and peripheral enable
    lfsr = next_rand(lfsr);
    m = 8'h01 << lfsr[2:0];
    apb(1'b1, OFF_CTRL, 32'h00);
    apb(1'b1, OFF_PMASK1, {24'h0, m});
    periph_evt_1 <= m;
    periph_evt_2 <= 8'hFF;
    idle(1);
    periph_evt_1 <= 8'h00;
    periph_evt_2 <= 8'h00;
    rd_chk("periph flag 1", OFF_PFLAG1, {24'h0, m});
    rd_chk("periph flag 2", OFF_PFLAG2, {24'h0, PFLAG2_MASK});
    chk("pending no peripheral_irq_enable", 32'h0, {31'h0, irq_pending});
    apb(1'b1, OFF_CTRL, 32'h40);
    idle(2);
    chk("pending peripheral_irq_enable", 32'h1, {31'h0, irq_pending});
    apb(1'b1, OFF_PMASK1, 32'h00);
    idle(2);
    chk("pending masked", 32'h0, {31'h0, irq_pending});
    apb(1'b1, OFF_PFLAG1, 32'h00);
    apb(1'b1, OFF_PFLAG2, 32'h00);
    // Take only with global enable, at random instruction length
    gap <= lfsr[4:3];
    apb(1'b1, OFF_CTRL, 32'h10);
    ext_irq_pin <= 1'b0;
    idle(4);
    ext_irq_pin <= 1'b1;
    wait_take(1'b0);
    apb(1'b1, OFF_CTRL, 32'h92);
    wait_take(1'b1);
    rd_chk("gie after take", OFF_CTRL, 32'h12);
    apb(1'b1, OFF_CTRL, 32'h10);
    return_from_irq <= 1'b1;
    idle(1);
    return_from_irq <= 1'b0;
    rd_chk("gie after return", OFF_CTRL, 32'h90);
    wait_take(1'b0);
    // Sleep, then wake on pin edge and vector
    ext_irq_pin <= 1'b0;
    sleep_req <= 1'b1;
    idle(1);
    sleep_req <= 1'b0;
    idle(3);
    chk("asleep", 32'h1, {31'h0, core_asleep});
    ext_irq_pin <= 1'b1;
    wait_take(1'b1);
    chk("awake", 32'h0, {31'h0, core_asleep});
    // Second reset clears external enable and flag; the take already cleared global enable
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    rd_chk("ctrl after reset", OFF_CTRL, 32'h00);
    give_verdict();
  end
endmodule
